/* verilog/gwt_timers.v */
/*
  General-purpose and watchdog up-counting timers with their register file.
  Assumes the register port is driven from logic on clk (one-cycle strobes),
  and the tick inputs are one-cycle pulses already on clk.
*/
`timescale 1ns/10ps
`include "gwt_defines.vh"

module gwt_timers (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire reg_rd_en,
  output reg [7:0] reg_rd_data,
  input wire [3:0] gp_tick_in,
  input wire [3:0] wd_tick_in,
  output reg irq,
  output reg gp_timeout_out,
  output reg wd_timeout_out
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg watchdog_run_bit;
  reg gp_run_bit;
  reg gp_timeout_flag;
  reg wd_timeout_flag;
  reg [7:0] gp_terminal_count;
  reg [7:0] wd_terminal_count;
  reg [1:0] gp_tick_select;
  reg [1:0] wd_tick_select;
  reg gp_irq_enable;
  reg wd_irq_enable;
  reg [7:0] gp_cnt_reg;
  reg [7:0] wd_cnt_reg;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input en;
    begin
      wr_hit = en && (addr == target);
    end
  endfunction

  wire wr_wd_run = wr_hit(reg_addr, `GWT_ADDR_WD_RUN, reg_wr_en);
  wire wr_gp_run = wr_hit(reg_addr, `GWT_ADDR_GP_RUN, reg_wr_en);
  wire wr_status = wr_hit(reg_addr, `GWT_ADDR_STATUS, reg_wr_en);
  wire wr_gp_term = wr_hit(reg_addr, `GWT_ADDR_GP_TERM, reg_wr_en);
  wire wr_wd_term = wr_hit(reg_addr, `GWT_ADDR_WD_TERM, reg_wr_en);
  wire wr_sel = wr_hit(reg_addr, `GWT_ADDR_TICK_SEL, reg_wr_en);
  wire wr_irq_en = wr_hit(reg_addr, `GWT_ADDR_IRQ_EN, reg_wr_en);

  wire wd_restart = wr_wd_run && reg_wr_data[`GWT_WD_RESTART_BIT];

  // ------------------------------------------------------------
  // Tick selection and timeout detection
  // ------------------------------------------------------------
  wire gp_tick = gp_tick_in[gp_tick_select];
  wire wd_tick = wd_tick_in[wd_tick_select];

  // Terminal count of zero times out at once; the compare is on the held count
  wire gp_expire = gp_run_bit && (gp_cnt_reg == gp_terminal_count);
  // A restart in the same cycle as expiry wins, so a last-moment kick saves the system
  wire wd_expire = watchdog_run_bit && (wd_cnt_reg == wd_terminal_count) && !wd_restart;

  reg gp_timeout_next;
  reg wd_timeout_next;

  always @* begin
    gp_timeout_next = gp_timeout_flag;
    wd_timeout_next = wd_timeout_flag;
    if (wr_status && reg_wr_data[`GWT_GP_FLAG_BIT]) begin
      gp_timeout_next = 1'b0;
    end
    if (wr_status && reg_wr_data[`GWT_WD_FLAG_BIT]) begin
      wd_timeout_next = 1'b0;
    end
    // Set after clear so a timeout in the clearing cycle is kept
    if (gp_expire) begin
      gp_timeout_next = 1'b1;
    end
    if (wd_expire) begin
      wd_timeout_next = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Registers and counters
  // ------------------------------------------------------------
  reg gp_run_next;
  reg watchdog_run_next;
  reg [7:0] gp_cnt_next;
  reg [7:0] wd_cnt_next;
  reg [7:0] gp_terminal_next;
  reg [7:0] wd_terminal_next;
  reg [1:0] gp_tick_select_next;
  reg [1:0] wd_tick_select_next;
  reg gp_irq_enable_next;
  reg wd_irq_enable_next;
  reg irq_next;
  reg [7:0] rd_data_next;

  // ------------------------------------------------------------
  // Configuration next values
  // ------------------------------------------------------------
  always @* begin
    gp_terminal_next = gp_terminal_count;
    wd_terminal_next = wd_terminal_count;
    gp_tick_select_next = gp_tick_select;
    wd_tick_select_next = wd_tick_select;
    gp_irq_enable_next = gp_irq_enable;
    wd_irq_enable_next = wd_irq_enable;
    if (wr_gp_term) begin
      gp_terminal_next = reg_wr_data;
    end
    if (wr_wd_term) begin
      wd_terminal_next = reg_wr_data;
    end
    // Reserved bits of the select register are dropped, not stored
    if (wr_sel) begin
      gp_tick_select_next = reg_wr_data[`GWT_GP_SEL_LSB +: 2];
      wd_tick_select_next = reg_wr_data[`GWT_WD_SEL_LSB +: 2];
    end
    if (wr_irq_en) begin
      gp_irq_enable_next = reg_wr_data[`GWT_GP_FLAG_BIT];
      wd_irq_enable_next = reg_wr_data[`GWT_WD_FLAG_BIT];
    end
  end

  // ------------------------------------------------------------
  // General-purpose timer next values
  // ------------------------------------------------------------
  always @* begin
    gp_run_next = gp_run_bit;
    gp_cnt_next = gp_cnt_reg;
    // Expiry beats a coincident write of the run bit
    if (gp_expire) begin
      gp_run_next = 1'b0;
    end else if (wr_gp_run) begin
      gp_run_next = reg_wr_data[`GWT_RUN_BIT];
    end
    // A cleared run bit holds the counter at zero, so every run starts from zero
    if (gp_expire || !gp_run_bit) begin
      gp_cnt_next = `GWT_CNT_RESET;
    end else if (gp_tick) begin
      gp_cnt_next = gp_cnt_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Watchdog next values
  // ------------------------------------------------------------
  always @* begin
    watchdog_run_next = watchdog_run_bit;
    wd_cnt_next = wd_cnt_reg;
    // A restart keeps a running watchdog running
    if (wd_expire) begin
      watchdog_run_next = 1'b0;
    end else if (wr_wd_run) begin
      watchdog_run_next = reg_wr_data[`GWT_RUN_BIT] || (wd_restart && watchdog_run_bit);
    end
    if (wd_expire || wd_restart || !watchdog_run_bit) begin
      wd_cnt_next = `GWT_CNT_RESET;
    end else if (wd_tick) begin
      wd_cnt_next = wd_cnt_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Interrupt and read data next values
  // ------------------------------------------------------------
  // One flag in bit 0 and one in bit 4, the layout shared by status and enables
  function [7:0] pack_lo_hi;
    input lo;
    input hi;
    begin
      pack_lo_hi = {3'h0, hi, 3'h0, lo};
    end
  endfunction

  always @* begin
    // Built from the next flags so the request rises with the flag, not a cycle later
    irq_next = (gp_timeout_next && gp_irq_enable) || (wd_timeout_next && wd_irq_enable);
    rd_data_next = reg_rd_data;
    // Reserved bits, restart bit and unmapped addresses read zero
    if (reg_rd_en) begin
      case (reg_addr)
        `GWT_ADDR_WD_RUN: rd_data_next = {7'h00, watchdog_run_bit};
        `GWT_ADDR_GP_RUN: rd_data_next = {7'h00, gp_run_bit};
        `GWT_ADDR_STATUS: rd_data_next = pack_lo_hi(gp_timeout_flag, wd_timeout_flag);
        `GWT_ADDR_GP_TERM: rd_data_next = gp_terminal_count;
        `GWT_ADDR_WD_TERM: rd_data_next = wd_terminal_count;
        `GWT_ADDR_TICK_SEL: rd_data_next = {2'h0, wd_tick_select, 2'h0, gp_tick_select};
        `GWT_ADDR_IRQ_EN: rd_data_next = pack_lo_hi(gp_irq_enable, wd_irq_enable);
        default: rd_data_next = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Terminal count registers
  // ------------------------------------------------------------
  // Reset is taken even while ce is low; otherwise ce low freezes every flip-flop
  always @(posedge clk) begin
    if (reset) begin
      gp_terminal_count <= `GWT_TERM_RESET;
      wd_terminal_count <= `GWT_TERM_RESET;
    end else if (ce) begin
      gp_terminal_count <= gp_terminal_next;
      wd_terminal_count <= wd_terminal_next;
    end
  end

  // ------------------------------------------------------------
  // Tick select and interrupt enable registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      gp_tick_select <= `GWT_SEL_RESET;
      wd_tick_select <= `GWT_SEL_RESET;
      gp_irq_enable <= 1'b0;
      wd_irq_enable <= 1'b0;
    end else if (ce) begin
      gp_tick_select <= gp_tick_select_next;
      wd_tick_select <= wd_tick_select_next;
      gp_irq_enable <= gp_irq_enable_next;
      wd_irq_enable <= wd_irq_enable_next;
    end
  end

  // ------------------------------------------------------------
  // General-purpose timer registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      gp_run_bit <= 1'b0;
      gp_cnt_reg <= `GWT_CNT_RESET;
    end else if (ce) begin
      gp_run_bit <= gp_run_next;
      gp_cnt_reg <= gp_cnt_next;
    end
  end

  // ------------------------------------------------------------
  // Watchdog registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      watchdog_run_bit <= 1'b0;
      wd_cnt_reg <= `GWT_CNT_RESET;
    end else if (ce) begin
      watchdog_run_bit <= watchdog_run_next;
      wd_cnt_reg <= wd_cnt_next;
    end
  end

  // ------------------------------------------------------------
  // Timeout flags
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      gp_timeout_flag <= 1'b0;
      wd_timeout_flag <= 1'b0;
    end else if (ce) begin
      gp_timeout_flag <= gp_timeout_next;
      wd_timeout_flag <= wd_timeout_next;
    end
  end

  // ------------------------------------------------------------
  // Flag copy outputs
  // ------------------------------------------------------------
  // Separate flip-flops so the pins never carry a decode glitch
  always @(posedge clk) begin
    if (reset) begin
      gp_timeout_out <= 1'b0;
      wd_timeout_out <= 1'b0;
    end else if (ce) begin
      gp_timeout_out <= gp_timeout_next;
      wd_timeout_out <= wd_timeout_next;
    end
  end

  // ------------------------------------------------------------
  // Interrupt request and read data outputs
  // ------------------------------------------------------------
  // Read data holds its last value until the next read
  always @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
      reg_rd_data <= 8'h00;
    end else if (ce) begin
      irq <= irq_next;
      reg_rd_data <= rd_data_next;
    end
  end

endmodule // gwt_timers

/* verilog/gwt_defines.vh */
/*
  Constants for the general-purpose and watchdog timer block: register
  addresses, field positions, reset values and tick-select codes.
  Assumes it is included by its bare name from the timer design file.
*/
// Summary of operation
// - Watchdog run bit 0 enables counting; at 0 it holds the counter cleared; resets 0.
// - Writing 1 to watchdog bit 4 restarts the count; it stores nothing, reads 0.
// - General-purpose run bit 0 enables counting; at 0 counter held cleared; resets 0.
// - Status bit 0 sets at general-purpose timeout, cleared only by writing 1.
// - Status bit 4 sets at watchdog timeout, cleared only by writing 1.
// - Each timer has an 8-bit terminal count register resetting to all ones.
// - General-purpose tick select bits 1:0: 32.768 kHz, 1024 Hz, 1 Hz, minute.
// - Interrupt enable bit 0 gates the general-purpose timeout interrupt; resets 0.
// - Interrupt enable bit 4 gates the watchdog timeout interrupt; resets 0.
// - Running timer counts ticks to terminal count, then flags and may interrupt.
// - Timeout or run bit cleared stops the timer, clears counter; settings kept.
// - Watchdog timeout stops it and clears counter and run bit; restart avoids it.
// - A restart write zeroes the watchdog counter and counting resumes by itself.
`ifndef GWT_DEFINES_VH
`define GWT_DEFINES_VH

`define GWT_ADDR_WD_RUN 8'ha0
`define GWT_ADDR_GP_RUN 8'ha1
`define GWT_ADDR_STATUS 8'ha2
`define GWT_ADDR_GP_TERM 8'ha3
`define GWT_ADDR_WD_TERM 8'ha4
`define GWT_ADDR_TICK_SEL 8'ha5
`define GWT_ADDR_IRQ_EN 8'ha6

`define GWT_RUN_BIT 0
`define GWT_WD_RESTART_BIT 4
`define GWT_GP_FLAG_BIT 0
`define GWT_WD_FLAG_BIT 4
`define GWT_GP_SEL_LSB 0
`define GWT_WD_SEL_LSB 4

`define GWT_TERM_RESET 8'hff
`define GWT_SEL_RESET 2'h0
`define GWT_CNT_RESET 8'h00

// Tick-select codes; tick input bit n carries the source of code n
`define GWT_GP_SEL_32K 2'h0
`define GWT_GP_SEL_1K 2'h1
`define GWT_GP_SEL_1HZ 2'h2
`define GWT_GP_SEL_MIN 2'h3
`define GWT_WD_SEL_8HZ 2'h0
`define GWT_WD_SEL_1HZ 2'h1
`define GWT_WD_SEL_HALF 2'h2
`define GWT_WD_SEL_MIN 2'h3

`endif

/* sim/gwt_timers_assertions.sv */
/* Port checker for gwt_timers.
   Assumes it is bound to the gwt_timers top module. */
`timescale 1ns/10ps
module gwt_timers_checker (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire reg_rd_en,
  input wire [7:0] reg_rd_data,
  input wire irq,
  input wire gp_timeout_out,
  input wire wd_timeout_out
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd(a);
    ce && reg_rd_en && reg_addr == a;
  endsequence
  a_irq_needs_flag: assert property (irq |-> gp_timeout_out || wd_timeout_out)
    else $error("irq high with no flag");
  a_reset_clears: assert property (disable iff (1'b0) reset && ce |=> !irq && !gp_timeout_out && !wd_timeout_out)
    else $error("reset left an output high");
  a_gp_flag_sticky: assert property (gp_timeout_out && !(ce && reg_wr_en && reg_addr == 8'ha2 && reg_wr_data[0]) |=> gp_timeout_out)
    else $error("gp flag dropped without clear");
  a_wd_flag_sticky: assert property (wd_timeout_out && !(ce && reg_wr_en && reg_addr == 8'ha2 && reg_wr_data[4]) |=> wd_timeout_out)
    else $error("wd flag dropped without clear");
  a_status_read: assert property (s_rd(8'ha2) |=> reg_rd_data == {3'h0, $past(wd_timeout_out), 3'h0, $past(gp_timeout_out)})
    else $error("status read differs from flags");
  a_reserved_zero: assert property (ce && reg_rd_en && reg_addr > 8'ha6 && reg_addr < 8'hb0 |=> reg_rd_data == 8'h00)
    else $error("reserved address read nonzero");
  a_restart_reads0: assert property (s_rd(8'ha0) |=> reg_rd_data[7:1] == 7'h00)
    else $error("watchdog control upper bits nonzero");
  a_gp_run_only: assert property (s_rd(8'ha1) |=> reg_rd_data[7:1] == 7'h00)
    else $error("gp control upper bits nonzero");
  a_tick_sel_mask: assert property (s_rd(8'ha5) |=> (reg_rd_data & 8'hcc) == 8'h00)
    else $error("tick select reserved bits nonzero");
endmodule // gwt_timers_checker

/* sim/gwt_timers_bench.sv */
/* Self-checking bench for gwt_timers: registers, both timers, irq.
   Assumes the design and its checker are compiled before it. */
`timescale 1ns/10ps
module gwt_timers_bench;
  reg clk = 0, reset = 1, ce = 1, reg_wr_en = 0, reg_rd_en = 0, rd_seen = 0;
  reg [7:0] reg_addr = 0, reg_wr_data = 0, v, i, s;
  reg [3:0] gp_tick_in = 0, wd_tick_in = 0;
  wire [7:0] reg_rd_data;
  wire irq, gp_timeout_out, wd_timeout_out;
  logic [7:0] exp_q[$];
  int n_errors = 0, n_tests = 0;
  gwt_timers DUT (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .gp_tick_in(gp_tick_in),
    .wd_tick_in(wd_tick_in), .irq(irq), .gp_timeout_out(gp_timeout_out), .wd_timeout_out(wd_timeout_out));
  initial forever #25 clk = ~clk;
  // ------------------------------
  // Helpers
  // ------------------------------
  task report_and_stop;
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, e);
    n_tests++;
    if (seen !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= w;
    reg_rd_en <= !w;
    @(posedge clk);
    reg_wr_en <= 0;
    reg_rd_en <= 0;
  endtask
  task rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    acc(0, a, 0);
  endtask
  task tick(input logic [3:0] g, w);
    @(posedge clk);
    gp_tick_in <= g;
    wd_tick_in <= w;
    @(posedge clk);
    gp_tick_in <= 0;
    wd_tick_in <= 0;
  endtask
  // Read data lands one cycle after the read is taken
  always @(posedge clk) rd_seen <= reg_rd_en;
  always @(negedge clk) if (rd_seen) chk("reg_rd_data", reg_rd_data, exp_q.pop_front());
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    v = $urandom(5);
    repeat (6) @(posedge clk);
    reset <= 0;
    for (i = 0; i < 9; i++) rd(8'ha0 + i, (i == 3 || i == 4) ? 8'hff : 8'h00);
    for (i = 3; i < 8; i++) begin
      v = $urandom;
      if (i != 7) acc(1, 8'ha0 + i, v);
      rd(8'ha0 + i, i == 5 ? v & 8'h33 : i == 6 ? v & 8'h11 : i == 7 ? 8'h00 : v);
    end
    for (s = 0; s < 4; s++) begin
      acc(1, 8'ha5, s);
      acc(1, 8'ha3, 8'h03);
      acc(1, 8'ha6, 8'h01);
      acc(1, 8'ha1, 8'h01);
      repeat (2) tick(~(4'h1 << s), 4'hf);
      repeat (2) tick(4'h1 << s, 0);
      rd(8'ha2, 8'h00);
      tick(4'h1 << s, 0);
      rd(8'ha2, 8'h01);
      @(negedge clk) chk("irq", irq, 1);
      rd(8'ha1, 8'h00);
      rd(8'ha3, 8'h03);
      acc(1, 8'ha2, 8'h01);
      @(negedge clk) chk("irq", irq, 0);
    end
    for (s = 0; s < 4; s++) begin
      acc(1, 8'ha5, s << 4);
      acc(1, 8'ha4, 8'h02);
      acc(1, 8'ha6, s == 3 ? 8'h00 : 8'h10);
      acc(1, 8'ha0, 8'h01);
      tick(0, 4'h1 << s);
      acc(1, 8'ha0, 8'h10);
      tick(0, 4'h1 << s);
      rd(8'ha0, 8'h01);
      rd(8'ha2, 8'h00);
      tick(0, 4'h1 << s);
      rd(8'ha2, 8'h10);
      @(negedge clk) chk("irq", irq, s != 3);
      rd(8'ha0, 8'h00);
      acc(1, 8'ha2, 8'h10);
    end
    acc(1, 8'ha1, 8'h01);
    repeat (2) tick(4'h1, 0);
    acc(1, 8'ha1, 8'h00);
    acc(1, 8'ha1, 8'h01);
    repeat (2) tick(4'h1, 0);
    rd(8'ha2, 8'h00);
    @(posedge clk) ce <= 0;
    tick(4'h1, 0);
    @(posedge clk) ce <= 1;
    rd(8'ha2, 8'h00);
    tick(4'h1, 0);
    rd(8'ha2, 8'h01);
    repeat (2) @(posedge clk);
    report_and_stop;
  end
endmodule // gwt_timers_bench

bind gwt_timers gwt_timers_checker u_chk (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .irq(irq), .gp_timeout_out(gp_timeout_out), .wd_timeout_out(wd_timeout_out));
